/* ctrl_pin_map.svh */
// Offsets, field positions, reset values and timing counts of the control-pin block
`ifndef CTRL_PIN_MAP_SVH
`define CTRL_PIN_MAP_SVH
// ----------------------------------------
// Register map
// ----------------------------------------
`define BOOT_LOAD_STATUS_ADDR 8'h02
`define PD_CTRL_ADDR 8'h10
`define GPIO_CTRL_ADDR 8'h11
`define STATUS_DONE_BIT 0
`define STATUS_OK_BIT 1
`define STATUS_NOMEM_BIT 2
`define STATUS_RDERR_BIT 3
`define STATUS_TEST_BIT 4
`define PD_CTRL_RESET 5'h00
`define GPIO_CTRL_RESET 10'h000
// ----------------------------------------
// Bus addresses
// ----------------------------------------
`define SLAVE_ADDR_BASE 8'h68
`define MASTER_ADDR_BASE 8'hA0
`define ADDR_SELECT_WEIGHT 8'h02
// ----------------------------------------
// Timing
// ----------------------------------------
`define CLOCK_PERIOD_NS 10
`define FALLBACK_TIME_MS 100
`define FALLBACK_CYCLES ((`FALLBACK_TIME_MS * 1000000) / `CLOCK_PERIOD_NS)
`endif

/* ctrl_pin_pkg.sv */
// Types of the control-pin block
package ctrl_pin_pkg;
   typedef enum logic [2:0] {
      ST_INIT, ST_BOOT, ST_STATUS, ST_SLAVE_ON, ST_DONE
   } seq_state_t;
   typedef enum logic [1:0] {
      MODE_NONE, MODE_MUTED, MODE_PASS, MODE_USER
   } run_mode_t;
   typedef struct packed {
      logic [1:0] dac_pd;
      logic [1:0] adc_pd;
      logic ref_pd;
   } pd_ctrl_t;
   typedef struct packed {
      logic [3:0] oe;
      logic [3:0] out;
      logic sdin3_sel;
      logic sdin4_sel;
   } gpio_ctrl_t;
endpackage

/* level_sync.sv */
// Two-stage level synchroniser
`timescale 1ns/1ps
module level_sync #(
   parameter int WIDTH = 1
) (
   input wire logic clock_i,
   input wire logic rst_i,
   input wire logic [WIDTH-1:0] d_i,
   output logic [WIDTH-1:0] q_o
);
   logic [WIDTH-1:0] stage;
   always_ff @(posedge clock_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         stage <= '0;
         q_o <= '0;
      end
      else
      begin
         stage <= d_i;
         q_o <= stage;
      end
   end
endmodule // level_sync

/* ctrl_pin_top.sv */
// Control pins, power-down, address select and boot fallback sequencing
// Notes on behaviour
// - Regulator shutdown powers off, loses registers
// - Default standby stops clocks, analog, volume
// - Failed boot plus low standby: power-down
// - After good boot, firmware defines standby
// - Each converter pair individually power-downable
// - Reference down only when converters down
// - Address pin selects slave/master addresses
// - General pins sampled by level only
// - Boot pin is input at power-up
// - Failed boot: high mutes, low enables
// - Good boot: pin driven low, firmware owns
// - Pins three, four serve as audio inputs
// - Failed high: default, audio outputs off
// - Status, then slave, then pin low
// - Memory read error recorded at 0x02
// - Failed low: pass inputs to outputs
// - No memory: done about 100 ms
// - Programmed pins configurable in and out
// - Address pin sets address bit one
// - Master and slave never both active
// - Unused register bits read zero
`timescale 1ns/1ps
`include "ctrl_pin_map.svh"
module ctrl_pin_top
   import ctrl_pin_pkg::*;
#(
   parameter int FALLBACK_CYCLES = `FALLBACK_CYCLES
) (
   // Clock and reset
   input wire logic clock_i,
   input wire logic rst_i,
   // Power pins
   input wire logic regulator_shutdown_pin_i,
   input wire logic standby_powerdown_input_i,
   input wire logic address_select_pin_i,
   // Boot loader status
   input wire logic boot_done_i,
   input wire logic boot_ok_i,
   input wire logic boot_nomem_i,
   input wire logic boot_rderr_i,
   input wire logic fw_standby_i,
   // Controller register port
   input wire logic reg_wr_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic [31:0] reg_wdata_i,
   output logic [31:0] reg_rdata_o,
   // General pins
   input wire logic [3:0] gpio_in_i,
   output logic [3:0] gpio_out_o,
   output logic [3:0] gpio_oe_o,
   // Serial audio
   input wire logic serial_audio_in_one_i,
   input wire logic serial_audio_in_two_i,
   output logic serial_audio_out_one_o,
   output logic serial_audio_out_two_o,
   output logic sdin_one_sel_o,
   output logic sdin_two_sel_o,
   // Power controls
   output logic regulators_on_o,
   output logic clocks_stop_o,
   output logic analog_pd_o,
   output logic volume_ramp_down_o,
   output logic [1:0] dac_pd_o,
   output logic [1:0] adc_pd_o,
   output logic ref_pd_o,
   output logic analog_out_mute_o,
   // Bus interfaces
   output logic master_bus_en_o,
   output logic slave_bus_en_o,
   output logic [7:0] slave_addr_o,
   output logic [7:0] master_addr_o
);
   // ----------------------------------------
   // Internal reset and pin sampling
   // ----------------------------------------
   logic rst_all;
   logic [3:0] gpio_s;
   logic standby_s;
   assign rst_all = rst_i | regulator_shutdown_pin_i;
   assign regulators_on_o = ~regulator_shutdown_pin_i;
   level_sync #(.WIDTH(5)) u_sync (
      .clock_i(clock_i),
      .rst_i(rst_all),
      .d_i({standby_powerdown_input_i, gpio_in_i}),
      .q_o({standby_s, gpio_s})
   );

   // ----------------------------------------
   // Boot sequencer
   // ----------------------------------------
   seq_state_t state;
   seq_state_t next_state;
   run_mode_t mode;
   run_mode_t next_mode;
   logic [31:0] timer;
   logic [31:0] status;
   logic timer_done;
   logic boot_end;
   logic [3:0] boot_flags;
   logic boot_good;
   assign timer_done = (timer >= 32'(FALLBACK_CYCLES - 1));
   assign boot_end = boot_done_i | timer_done;

   // Loader result held from boot end, since done may be a one-cycle pulse
   always_ff @(posedge clock_i or posedge rst_all)
   begin
      if (rst_all)
         boot_flags <= 4'h0;
      else if (state == ST_BOOT && boot_end)
         boot_flags <= {boot_done_i, boot_ok_i, boot_nomem_i, boot_rderr_i};
   end
   assign boot_good = boot_flags[3] & boot_flags[2] & ~boot_flags[0];
   always_comb
   begin
      next_state = state;
      next_mode = mode;
      case (state)
         ST_INIT: next_state = ST_BOOT;
         ST_BOOT:
            if (boot_end)
               next_state = ST_STATUS;
         ST_STATUS: next_state = ST_SLAVE_ON;
         ST_SLAVE_ON:
         begin
            next_state = ST_DONE;
            if (status[`STATUS_OK_BIT])
               next_mode = MODE_USER;
            else if (gpio_s[0])
               next_mode = MODE_MUTED;
            else
               next_mode = MODE_PASS;
         end
         ST_DONE: next_state = ST_DONE;
         default: next_state = ST_INIT;
      endcase
   end
   always_ff @(posedge clock_i or posedge rst_all)
   begin
      if (rst_all)
      begin
         state <= ST_INIT;
         mode <= MODE_NONE;
         timer <= 32'h0000_0000;
      end
      else
      begin
         state <= next_state;
         mode <= next_mode;
         if (state == ST_BOOT && !timer_done)
            timer <= timer + 32'h0000_0001;
      end
   end
   always_ff @(posedge clock_i or posedge rst_all)
   begin
      if (rst_all)
         status <= 32'h0000_0000;
      else if (state == ST_STATUS)
      begin
         status[`STATUS_DONE_BIT] <= 1'b1;
         status[`STATUS_OK_BIT] <= boot_good;
         status[`STATUS_NOMEM_BIT] <= boot_flags[1] | ~boot_flags[3];
         status[`STATUS_RDERR_BIT] <= boot_flags[0];
         status[`STATUS_TEST_BIT] <= ~gpio_s[0] & ~boot_good;
      end
   end

   // ----------------------------------------
   // Bus enables and addresses
   // ----------------------------------------
   assign master_bus_en_o = (state == ST_BOOT) || (state == ST_STATUS);
   assign slave_bus_en_o = (state == ST_SLAVE_ON) || (state == ST_DONE);
   assign slave_addr_o = `SLAVE_ADDR_BASE
      | (address_select_pin_i ? `ADDR_SELECT_WEIGHT : 8'h00);
   assign master_addr_o = `MASTER_ADDR_BASE
      | (address_select_pin_i ? `ADDR_SELECT_WEIGHT : 8'h00);

   // ----------------------------------------
   // Controller registers
   // ----------------------------------------
   pd_ctrl_t pd;
   gpio_ctrl_t gc;
   logic pd_wr;
   logic gc_wr;
   logic ref_ok;
   assign pd_wr = reg_wr_i && slave_bus_en_o && (reg_addr_i == `PD_CTRL_ADDR);
   assign gc_wr = reg_wr_i && (mode == MODE_USER) && (reg_addr_i == `GPIO_CTRL_ADDR);
   assign ref_ok = (&reg_wdata_i[3:0]);
   always_ff @(posedge clock_i or posedge rst_all)
   begin
      if (rst_all)
      begin
         pd <= pd_ctrl_t'(`PD_CTRL_RESET);
         gc <= gpio_ctrl_t'(`GPIO_CTRL_RESET);
      end
      else
      begin
         if (pd_wr)
         begin
            pd.dac_pd <= reg_wdata_i[1:0];
            pd.adc_pd <= reg_wdata_i[3:2];
            pd.ref_pd <= reg_wdata_i[4] & ref_ok;
         end
         if (gc_wr)
            gc <= reg_wdata_i[9:0];
      end
   end
   always_comb
   begin
      case (reg_addr_i)
         `BOOT_LOAD_STATUS_ADDR: reg_rdata_o = status;
         `PD_CTRL_ADDR: reg_rdata_o = {27'h0, pd.ref_pd, pd.adc_pd, pd.dac_pd};
         `GPIO_CTRL_ADDR: reg_rdata_o = {18'h0_0000, gpio_s, gc};
         default: reg_rdata_o = 32'h0000_0000;
      endcase
   end
   assign dac_pd_o = pd.dac_pd;
   assign adc_pd_o = pd.adc_pd;
   assign ref_pd_o = pd.ref_pd;

   // ----------------------------------------
   // Standby and fallback outputs
   // ----------------------------------------
   logic default_standby;
   logic standby;
   assign default_standby = (mode == MODE_MUTED || mode == MODE_PASS) && !standby_s;
   assign standby = (mode == MODE_USER) ? fw_standby_i : default_standby;
   assign clocks_stop_o = standby;
   assign analog_pd_o = standby;
   assign volume_ramp_down_o = standby;
   assign analog_out_mute_o = (mode == MODE_MUTED) || (mode == MODE_NONE);

   // General pin drive: boot pin low once sequence ends
   always_ff @(posedge clock_i or posedge rst_all)
   begin
      if (rst_all)
      begin
         gpio_out_o <= 4'h0;
         gpio_oe_o <= 4'h0;
      end
      else if (mode == MODE_USER)
      begin
         gpio_out_o <= gc.out;
         gpio_oe_o <= gc.oe | ((state == ST_DONE && gc == '0) ? 4'h1 : 4'h0);
      end
      else if (mode != MODE_NONE)
      begin
         gpio_out_o <= 4'h0;
         gpio_oe_o <= 4'h1;
      end
   end
   assign sdin_one_sel_o = (mode == MODE_USER) && gc.sdin3_sel;
   assign sdin_two_sel_o = (mode == MODE_USER) && gc.sdin4_sel;

   // Audio pass-through in test mode, outputs idle in muted default
   always_ff @(posedge clock_i or posedge rst_all)
   begin
      if (rst_all)
      begin
         serial_audio_out_one_o <= 1'b0;
         serial_audio_out_two_o <= 1'b0;
      end
      else
      begin
         serial_audio_out_one_o <= (mode == MODE_PASS) & serial_audio_in_one_i;
         serial_audio_out_two_o <= (mode == MODE_PASS) & serial_audio_in_two_i;
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   a_bus_exclusive: assert property (@(posedge clock_i) disable iff (rst_all)
      !(master_bus_en_o && slave_bus_en_o)) else $error("both buses active");
   a_status_before_pin: assert property (@(posedge clock_i) disable iff (rst_all)
      $rose(gpio_oe_o[0]) |-> slave_bus_en_o && status[`STATUS_DONE_BIT])
      else $error("pin driven before status");
   a_timeout_end: assert property (@(posedge clock_i) disable iff (rst_all)
      (state == ST_BOOT && timer_done) |=> state == ST_STATUS) else $error("timeout lost");
   a_ref_guard: assert property (@(posedge clock_i) disable iff (rst_all)
      $rose(ref_pd_o) |-> (&dac_pd_o) && (&adc_pd_o)) else $error("reference down early");
   a_pass_through: assert property (@(posedge clock_i) disable iff (rst_all)
      mode == MODE_PASS && $past(mode) == MODE_PASS |->
      serial_audio_out_one_o == $past(serial_audio_in_one_i)) else $error("no pass");
   a_muted_quiet: assert property (@(posedge clock_i) disable iff (rst_all)
      mode == MODE_MUTED |=> !serial_audio_out_one_o && !serial_audio_out_two_o)
      else $error("muted output active");
   a_fallback_standby: assert property (@(posedge clock_i) disable iff (rst_all)
      ((mode == MODE_MUTED || mode == MODE_PASS) && !standby_s) |-> clocks_stop_o && analog_pd_o)
      else $error("no standby");
   a_pin_input_boot: assert property (@(posedge clock_i) disable iff (rst_all)
      state == ST_BOOT |-> gpio_oe_o == 4'h0) else $error("pin driven in boot");
   a_addr_bit: assert property (@(posedge clock_i) disable iff (rst_all)
      slave_addr_o[1] == address_select_pin_i) else $error("address bit wrong");
   a_slave_after_boot: assert property (@(posedge clock_i) disable iff (rst_all)
      slave_bus_en_o |-> status[`STATUS_DONE_BIT]) else $error("slave before boot end");
   a_fallback_pin_low: assert property (@(posedge clock_i) disable iff (rst_all)
      (mode == MODE_MUTED || mode == MODE_PASS) |-> !gpio_out_o[0])
      else $error("boot pin not low");
   c_muted: cover property (@(posedge clock_i) disable iff (rst_all) mode == MODE_MUTED);
   c_pass: cover property (@(posedge clock_i) disable iff (rst_all) mode == MODE_PASS);
   c_user: cover property (@(posedge clock_i) disable iff (rst_all) mode == MODE_USER);
   c_rderr: cover property (@(posedge clock_i) disable iff (rst_all) status[`STATUS_RDERR_BIT]);
endmodule // ctrl_pin_top

/* board_ctrl_model.sv */
// Board controller model: pulls the boot pin and watches for its fall
`timescale 1ns/1ps
module board_ctrl_model (
   // Clock and reset
   input wire logic clock_i,
   input wire logic rst_i,
   // Boot pin
   input wire logic pull_high_i,
   input wire logic pin_oe_i,
   input wire logic pin_out_i,
   output logic pin_level_o,
   output logic fall_seen_o
);
   logic last_level;
   assign pin_level_o = pin_oe_i ? pin_out_i : pull_high_i;
   // ----------------------------------------
   // Status may be read only after the fall
   // ----------------------------------------
   always_ff @(posedge clock_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         last_level <= 1'b0;
         fall_seen_o <= 1'b0;
      end
      else
      begin
         last_level <= pin_level_o;
         if (last_level && !pin_level_o)
            fall_seen_o <= 1'b1;
      end
   end
endmodule // board_ctrl_model

/* control_pin_power_boot_fallback_test.sv */
// Testbench of the control-pin block
`timescale 1ns/1ps
module control_pin_power_boot_fallback_test;
   import ctrl_pin_pkg::*;
   logic clock_i = 1'b0, rst_i = 1'b1, reg_shut = 1'b0, standby = 1'b1, addr_sel = 1'b0;
   logic boot_done_i = 1'b0, boot_ok_i = 1'b0, boot_nomem_i = 1'b0, boot_rderr_i = 1'b0;
   logic fw_standby = 1'b0, reg_wr_i = 1'b0, ain_one = 1'b0, ain_two = 1'b0, pull_high = 1'b1;
   logic [7:0] reg_addr_i = 8'h00;
   logic [31:0] reg_wdata_i = 32'h0, reg_rdata_o;
   logic [2:0] gpio_hi = 3'h5;
   logic [3:0] gpio_out_o, gpio_oe_o;
   logic [1:0] dac_pd_o, adc_pd_o;
   logic [7:0] slave_addr_o, master_addr_o;
   logic out1, out2, sel1, sel2, reg_on, clk_stop, ana_pd, vol_down, ref_pd_o, mute;
   logic master_bus_en_o, slave_bus_en_o, pin_level, fall_seen;
   int n_mismatch = 0, checks_done = 0;
   always #5 clock_i = ~clock_i;
   ctrl_pin_top #(.FALLBACK_CYCLES(50)) dut_u (.clock_i(clock_i), .rst_i(rst_i),
      .regulator_shutdown_pin_i(reg_shut), .standby_powerdown_input_i(standby),
      .address_select_pin_i(addr_sel), .boot_done_i(boot_done_i), .boot_ok_i(boot_ok_i),
      .boot_nomem_i(boot_nomem_i), .boot_rderr_i(boot_rderr_i), .fw_standby_i(fw_standby),
      .reg_wr_i(reg_wr_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
      .reg_rdata_o(reg_rdata_o), .gpio_in_i({gpio_hi, pin_level}), .gpio_out_o(gpio_out_o),
      .gpio_oe_o(gpio_oe_o), .serial_audio_in_one_i(ain_one), .serial_audio_in_two_i(ain_two),
      .serial_audio_out_one_o(out1), .serial_audio_out_two_o(out2), .sdin_one_sel_o(sel1),
      .sdin_two_sel_o(sel2), .regulators_on_o(reg_on), .clocks_stop_o(clk_stop),
      .analog_pd_o(ana_pd), .volume_ramp_down_o(vol_down), .dac_pd_o(dac_pd_o),
      .adc_pd_o(adc_pd_o), .ref_pd_o(ref_pd_o), .analog_out_mute_o(mute),
      .master_bus_en_o(master_bus_en_o), .slave_bus_en_o(slave_bus_en_o),
      .slave_addr_o(slave_addr_o), .master_addr_o(master_addr_o));
   board_ctrl_model partner_u (.clock_i(clock_i), .rst_i(rst_i), .pull_high_i(pull_high),
      .pin_oe_i(gpio_oe_o[0]), .pin_out_i(gpio_out_o[0]), .pin_level_o(pin_level),
      .fall_seen_o(fall_seen));
   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      checks_done++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("mismatch at %0t: %s", $time, m);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock_i);
      reg_wr_i <= 1'b1;
      reg_addr_i <= a;
      reg_wdata_i <= d;
      @(posedge clock_i);
      reg_wr_i <= 1'b0;
      @(posedge clock_i);
      #1;
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string m);
      @(posedge clock_i);
      reg_addr_i <= a;
      #1 chk(reg_rdata_o, e, m);
   endtask
   task automatic wait_n(input int k);
      repeat (k) @(posedge clock_i);
      #1;
   endtask
   task automatic run_boot(input logic pull, input logic [2:0] res, input logic [31:0] st);
      int n;
      pull_high <= pull;
      rst_i <= 1'b1;
      repeat (3) @(posedge clock_i);
      rst_i <= 1'b0;
      wait_n(1);
      chk(master_bus_en_o, 1, "master on");
      chk(slave_bus_en_o, 0, "slave off");
      chk(gpio_oe_o[0], 0, "pin input");
      if (res != 3'b000)
      begin
         @(posedge clock_i);
         {boot_ok_i, boot_nomem_i, boot_rderr_i} <= res;
         boot_done_i <= 1'b1;
         @(posedge clock_i);
         boot_done_i <= 1'b0;
      end
      n = 0;
      while (gpio_oe_o[0] !== 1'b1 && n < 200)
      begin
         @(posedge clock_i);
         #1 n++;
      end
      chk(n < 200, 1, "pin driven");
      if (n >= 200)
         end_of_test();
      if (res == 3'b000)
         chk(n >= 45 && n <= 60, 1, "fallback time");
      chk(slave_bus_en_o, 1, "slave on before pin");
      chk(master_bus_en_o, 0, "master off");
      chk(gpio_out_o[0], 0, "pin low");
      wait_n(1);
      chk(fall_seen, pull, "fall seen");
      rd_chk(8'h02, st, "status");
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic s_addr;
      for (int i = 0; i < 2; i++)
      begin
         @(posedge clock_i);
         addr_sel <= i[0];
         #1 chk(slave_addr_o, {6'b011010, i[0], 1'b0}, "slave address");
         chk(master_addr_o, {6'b101000, i[0], 1'b0}, "master address");
      end
   endtask
   task automatic s_muted;
      run_boot(1'b1, 3'b000, 32'h05);
      ain_one <= 1'b1;
      ain_two <= 1'b1;
      wait_n(3);
      chk(mute, 1, "muted");
      chk({out1, out2}, 0, "outputs idle");
   endtask
   task automatic s_pass;
      run_boot(1'b0, 3'b001, 32'h19);
      chk(mute, 0, "output enabled");
      for (int p = 1; p < 3; p++)
      begin
         {ain_one, ain_two} <= p[1:0];
         wait_n(3);
         chk({out1, out2}, p[1:0], "pass through");
      end
      standby <= 1'b0;
      wait_n(4);
      chk({clk_stop, ana_pd, vol_down}, 3'h7, "standby");
      standby <= 1'b1;
      wait_n(4);
      chk({clk_stop, ana_pd, vol_down}, 3'h0, "awake");
   endtask
   task automatic s_user;
      run_boot(1'b1, 3'b100, 32'h03);
      standby <= 1'b0;
      wait_n(4);
      chk(clk_stop, 0, "fixed standby unused");
      fw_standby <= 1'b1;
      wait_n(4);
      chk(clk_stop, 1, "firmware standby");
      standby <= 1'b1;
      fw_standby <= 1'b0;
      wr(8'h10, 32'h10);
      chk(ref_pd_o, 0, "reference refused");
      wr(8'h10, 32'h05);
      chk({dac_pd_o, adc_pd_o}, 4'h5, "pair power-down");
      wr(8'h10, 32'h1F);
      chk(ref_pd_o, 1, "reference down");
      rd_chk(8'h10, 32'h1F, "power-down readback");
      wr(8'h11, 32'h192);
      chk({gpio_oe_o, gpio_out_o}, 8'h64, "pin config");
      chk({sel1, sel2}, 2'b10, "audio input select");
      wait_n(2);
      rd_chk(8'h11, 32'h0000_2D92, "pin levels");
      @(posedge clock_i);
      reg_shut <= 1'b1;
      wait_n(1);
      chk(reg_on, 0, "regulators off");
      chk(dac_pd_o, 0, "registers lost");
      reg_shut <= 1'b0;
      run_boot(1'b1, 3'b100, 32'h03);
      rd_chk(8'h10, 32'h0, "cleared after shutdown");
      chk(reg_on, 1, "regulators on");
   endtask
   initial
   begin
      s_addr();
      s_muted();
      s_pass();
      s_user();
      end_of_test();
   end
endmodule // control_pin_power_boot_fallback_test
